/* rtl/jtbs_defs.vh */
// constants for the test access port: scan lengths, instruction codes,
// identification fields and controller state codes.
// assumes it is included once per file by its bare name.
`ifndef JTBS_DEFS_VH
`define JTBS_DEFS_VH

// scan register lengths
`define JTBS_IR_LEN      8
`define JTBS_ID_LEN      32
`define JTBS_BSR_LEN     113

// instruction codes; only the bypass code is fixed, the others are plain choices
`define JTBS_OP_BYPASS   8'hff
`define JTBS_OP_IDCODE   8'h01
`define JTBS_OP_HIGHZ    8'h03
`define JTBS_OP_SAMPLE   8'h05
`define JTBS_IR_CAPTURE  8'h01

// identification field positions
`define JTBS_ID_REV_MSB  31
`define JTBS_ID_REV_LSB  28
`define JTBS_ID_DEV_MSB  27
`define JTBS_ID_DEV_LSB  12
`define JTBS_ID_VEN_MSB  11
`define JTBS_ID_VEN_LSB  1
`define JTBS_ID_PRESENT  1'h1

// controller states, one-hot
`define JTBS_ST_TLR      16'h0001
`define JTBS_ST_RTI      16'h0002
`define JTBS_ST_SDRS     16'h0004
`define JTBS_ST_CDR      16'h0008
`define JTBS_ST_SHDR     16'h0010
`define JTBS_ST_E1DR     16'h0020
`define JTBS_ST_PDR      16'h0040
`define JTBS_ST_E2DR     16'h0080
`define JTBS_ST_UDR      16'h0100
`define JTBS_ST_SIRS     16'h0200
`define JTBS_ST_CIR      16'h0400
`define JTBS_ST_SHIR     16'h0800
`define JTBS_ST_E1IR     16'h1000
`define JTBS_ST_PIR      16'h2000
`define JTBS_ST_E2IR     16'h4000
`define JTBS_ST_UIR      16'h8000

`endif

/* rtl/jtbs_tap_fsm.v */
// sixteen-state test controller, advanced once per detected test clock rise.
// assumes adv is a one-cycle pulse on core_clk and tms is already synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"

module jtbs_tap_fsm (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        adv,
	input  wire        tms,
	output reg  [15:0] state_reg
);

	// one-hot state codes, shared with the datapath through the header
	localparam [15:0] ST_TLR  = `JTBS_ST_TLR;
	localparam [15:0] ST_RTI  = `JTBS_ST_RTI;
	localparam [15:0] ST_SDRS = `JTBS_ST_SDRS;
	localparam [15:0] ST_CDR  = `JTBS_ST_CDR;
	localparam [15:0] ST_SHDR = `JTBS_ST_SHDR;
	localparam [15:0] ST_E1DR = `JTBS_ST_E1DR;
	localparam [15:0] ST_PDR  = `JTBS_ST_PDR;
	localparam [15:0] ST_E2DR = `JTBS_ST_E2DR;
	localparam [15:0] ST_UDR  = `JTBS_ST_UDR;
	localparam [15:0] ST_SIRS = `JTBS_ST_SIRS;
	localparam [15:0] ST_CIR  = `JTBS_ST_CIR;
	localparam [15:0] ST_SHIR = `JTBS_ST_SHIR;
	localparam [15:0] ST_E1IR = `JTBS_ST_E1IR;
	localparam [15:0] ST_PIR  = `JTBS_ST_PIR;
	localparam [15:0] ST_E2IR = `JTBS_ST_E2IR;
	localparam [15:0] ST_UIR  = `JTBS_ST_UIR;

	reg [15:0] state_next;

	// next state from mode select; power-up lands in test-logic-reset
	always @* begin
		case (state_reg)
			ST_TLR:  state_next = tms ? ST_TLR  : ST_RTI;
			ST_RTI:  state_next = tms ? ST_SDRS : ST_RTI;
			ST_SDRS: state_next = tms ? ST_SIRS : ST_CDR;
			ST_CDR:  state_next = tms ? ST_E1DR : ST_SHDR;
			ST_SHDR: state_next = tms ? ST_E1DR : ST_SHDR;
			ST_E1DR: state_next = tms ? ST_UDR  : ST_PDR;
			ST_PDR:  state_next = tms ? ST_E2DR : ST_PDR;
			ST_E2DR: state_next = tms ? ST_UDR  : ST_SHDR;
			ST_UDR:  state_next = tms ? ST_SDRS : ST_RTI;
			ST_SIRS: state_next = tms ? ST_TLR  : ST_CIR;
			ST_CIR:  state_next = tms ? ST_E1IR : ST_SHIR;
			ST_SHIR: state_next = tms ? ST_E1IR : ST_SHIR;
			ST_E1IR: state_next = tms ? ST_UIR  : ST_PIR;
			ST_PIR:  state_next = tms ? ST_E2IR : ST_PIR;
			ST_E2IR: state_next = tms ? ST_UIR  : ST_SHIR;
			ST_UIR:  state_next = tms ? ST_SDRS : ST_RTI;
			default: state_next = ST_TLR; // illegal code recovers
		endcase
	end

	// one step per test clock rise only
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_TLR;
		end else if (adv) begin
			state_reg <= state_next;
		end
	end

endmodule
`default_nettype wire

/* rtl/jtbs_tap.v */
// test access port with instruction, bypass, identification and boundary scan
// registers, sampling an externally driven test clock with core_clk.
// assumes the test clock is far slower than core_clk (at least four samples per
// phase) and that ball levels arrive from outside this clock domain.
// Summary of operation
// - with bypass held, shift-dr passes serial in to serial out through one bypass bit only.
// - instruction codes outside the defined set select the bypass bit, as the bypass code does.
// - instruction register is 8 bits, bypass 1 bit, identification 32 bits.
// - boundary scan register is 113 cells shifted out from cell 1 through cell 113.
// - cells of unused balls always read as zero.
// - identification bits 31:28 hold revision and bits 27:12 the device field.
// - identification bits 11:1 hold the vendor code.
// - identification bit 0 always reads one.
// - serial out changes on the falling test clock edge.
// - the all-ones code is bypass and leaves memory operation alone.
// - power-up and test-logic-reset load the identification instruction.
// - high-z connects the boundary scan register and floats all memory outputs.
// - sample/preload captures input and bidirectional balls in capture-dr.
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"

module jtbs_tap #(
	parameter [3:0]                REVISION  = 4'h0,     // arbitrary value
	parameter [15:0]               DEVICE_ID = 16'h0000, // arbitrary value
	parameter [10:0]               VENDOR_ID = 11'h000,  // arbitrary value
	parameter [`JTBS_BSR_LEN-1:0]  USED_MASK = {`JTBS_BSR_LEN{1'b1}}
) (
	input  wire                      core_clk,
	input  wire                      rst_n,
	input  wire                      tck,
	input  wire                      tms,
	input  wire                      tdi,
	input  wire [`JTBS_BSR_LEN-1:0]  ball_in,
	output reg                       tdo_reg,
	output reg                       tdo_oe_reg,
	output reg                       mem_hiz_reg,
	output reg  [`JTBS_BSR_LEN-1:0]  bsr_upd_reg,
	output reg  [`JTBS_IR_LEN-1:0]   ir_reg
);

	// pin synchronisers: first stage feeds only the second
	reg                      tck_s1_reg;
	reg                      tck_s2_reg;
	reg                      tck_d_reg;
	reg                      tms_s1_reg;
	reg                      tms_s2_reg;
	reg                      tdi_s1_reg;
	reg                      tdi_s2_reg;
	reg [`JTBS_BSR_LEN-1:0]  ball_s1_reg;
	reg [`JTBS_BSR_LEN-1:0]  ball_s2_reg;

	// scan shift registers
	reg [`JTBS_IR_LEN-1:0]   ir_sh_reg;
	reg                      byp_reg;
	reg [`JTBS_ID_LEN-1:0]   id_sh_reg;
	reg [`JTBS_BSR_LEN-1:0]  bsr_sh_reg;

	wire [15:0]              state;
	wire                     tck_rise;
	wire                     tck_fall;
	wire [`JTBS_ID_LEN-1:0]  id_value;
	reg                      sel_bsr;
	reg                      sel_id;
	reg                      dr_out;

	// controller states this datapath acts on, one-hot; the machine itself
	// lives in its own module so the datapath only decodes its output
	localparam [15:0] ST_TLR  = `JTBS_ST_TLR;
	localparam [15:0] ST_CDR  = `JTBS_ST_CDR;
	localparam [15:0] ST_SHDR = `JTBS_ST_SHDR;
	localparam [15:0] ST_UDR  = `JTBS_ST_UDR;
	localparam [15:0] ST_CIR  = `JTBS_ST_CIR;
	localparam [15:0] ST_SHIR = `JTBS_ST_SHIR;
	localparam [15:0] ST_UIR  = `JTBS_ST_UIR;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s1_reg  <= 1'b0;
			tck_s2_reg  <= 1'b0;
			tck_d_reg   <= 1'b0;
			tms_s1_reg  <= 1'b1;
			tms_s2_reg  <= 1'b1;
			tdi_s1_reg  <= 1'b0;
			tdi_s2_reg  <= 1'b0;
			ball_s1_reg <= {`JTBS_BSR_LEN{1'b0}};
			ball_s2_reg <= {`JTBS_BSR_LEN{1'b0}};
		end else begin
			tck_s1_reg  <= tck;
			tck_s2_reg  <= tck_s1_reg;
			tck_d_reg   <= tck_s2_reg;
			tms_s1_reg  <= tms;
			tms_s2_reg  <= tms_s1_reg;
			tdi_s1_reg  <= tdi;
			tdi_s2_reg  <= tdi_s1_reg;
			ball_s1_reg <= ball_in;
			ball_s2_reg <= ball_s1_reg;
		end
	end

	// edges seen two core cycles late; tdi and tms lag equally so stay aligned
	assign tck_rise = tck_s2_reg & ~tck_d_reg;
	assign tck_fall = ~tck_s2_reg & tck_d_reg;

	jtbs_tap_fsm u_fsm (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.adv       (tck_rise),
		.tms       (tms_s2_reg),
		.state_reg (state)
	);

	// identification word; bit 0 hard-wired high
	assign id_value[`JTBS_ID_REV_MSB:`JTBS_ID_REV_LSB] = REVISION;
	assign id_value[`JTBS_ID_DEV_MSB:`JTBS_ID_DEV_LSB] = DEVICE_ID;
	assign id_value[`JTBS_ID_VEN_MSB:`JTBS_ID_VEN_LSB] = VENDOR_ID;
	assign id_value[0]                                 = `JTBS_ID_PRESENT;

	// data register selection; unknown codes fall back to the bypass bit
	always @* begin
		sel_bsr = 1'b0;
		sel_id  = 1'b0;
		case (ir_reg)
			`JTBS_OP_IDCODE: sel_id  = 1'b1;
			`JTBS_OP_HIGHZ:  sel_bsr = 1'b1;
			`JTBS_OP_SAMPLE: sel_bsr = 1'b1;
			`JTBS_OP_BYPASS: sel_bsr = 1'b0;
			default:         sel_bsr = 1'b0;
		endcase
	end

	// serial-out source of the selected data register
	always @* begin
		if (sel_bsr) begin
			dr_out = bsr_sh_reg[0];
		end else if (sel_id) begin
			dr_out = id_sh_reg[0];
		end else begin
			dr_out = byp_reg;
		end
	end

	// instruction path: capture fixed pattern, shift lsb first, update in update-ir
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_sh_reg <= `JTBS_IR_CAPTURE;
			ir_reg    <= `JTBS_OP_IDCODE;
		end else if (tck_rise) begin
			case (state)
				ST_TLR:  ir_reg <= `JTBS_OP_IDCODE;
				ST_CIR:  ir_sh_reg <= `JTBS_IR_CAPTURE;
				ST_SHIR: ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[`JTBS_IR_LEN-1:1]};
				ST_UIR:  ir_reg <= ir_sh_reg;
				default: ir_sh_reg <= ir_sh_reg;
			endcase
		end
	end

	// data path: only the selected register captures and shifts
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			byp_reg     <= 1'b0;
			id_sh_reg   <= {`JTBS_ID_LEN{1'b0}};
			bsr_sh_reg  <= {`JTBS_BSR_LEN{1'b0}};
			bsr_upd_reg <= {`JTBS_BSR_LEN{1'b0}};
		end else if (tck_rise) begin
			if (state == ST_CDR) begin
				if (sel_bsr) begin
					bsr_sh_reg <= ball_s2_reg & USED_MASK;
				end else if (sel_id) begin
					id_sh_reg <= id_value;
				end else begin
					byp_reg <= 1'b0;
				end
			end else if (state == ST_SHDR) begin
				if (sel_bsr) begin
					// cell 1 sits at bit 0 and leaves first
					bsr_sh_reg <= {tdi_s2_reg, bsr_sh_reg[`JTBS_BSR_LEN-1:1]};
				end else if (sel_id) begin
					id_sh_reg <= {tdi_s2_reg, id_sh_reg[`JTBS_ID_LEN-1:1]};
				end else begin
					byp_reg <= tdi_s2_reg;
				end
			end else if (state == ST_UDR && sel_bsr) begin
				// preload value held for later drive; unused cells stay low
				bsr_upd_reg <= bsr_sh_reg & USED_MASK;
			end
		end
	end

	// serial out moves only on the test clock fall, so the far end samples a
	// stable bit at its next rise; enable follows the shift states
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else if (tck_fall) begin
			if (state == ST_SHDR) begin
				tdo_reg    <= dr_out;
				tdo_oe_reg <= 1'b1;
			end else if (state == ST_SHIR) begin
				tdo_reg    <= ir_sh_reg[0];
				tdo_oe_reg <= 1'b1;
			end else begin
				tdo_oe_reg <= 1'b0;
			end
		end
	end

	// memory outputs float for as long as high-z is the active instruction
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_hiz_reg <= 1'b0;
		end else begin
			mem_hiz_reg <= (ir_reg == `JTBS_OP_HIGHZ);
		end
	end

endmodule
`default_nettype wire

/* dv/jtbs_tap_asserts.sv */
// checker on the test access port outputs
// assumes it is bound to jtbs_tap and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"
module jtbs_tap_asserts #(
	parameter [`JTBS_BSR_LEN-1:0] USED_MASK = {`JTBS_BSR_LEN{1'b1}}
) (
	input wire logic                     core_clk,
	input wire logic                     rst_n,
	input wire logic                     tck,
	input wire logic                     tms,
	input wire logic                     tdi,
	input wire logic [`JTBS_BSR_LEN-1:0] ball_in,
	input wire logic                     tdo_reg,
	input wire logic                     tdo_oe_reg,
	input wire logic                     mem_hiz_reg,
	input wire logic [`JTBS_BSR_LEN-1:0] bsr_upd_reg,
	input wire logic [`JTBS_IR_LEN-1:0]  ir_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// mem_hiz lags ir_reg by a clock, so the code must be seen twice
	sequence s_hiz_held;
		ir_reg == `JTBS_OP_HIGHZ ##1 ir_reg == `JTBS_OP_HIGHZ;
	endsequence
	property p_hiz_on; s_hiz_held |-> mem_hiz_reg; endproperty
	a_hiz_on: assert property (p_hiz_on) else $error("hiz not raised");
	property p_hiz_off; ir_reg != `JTBS_OP_HIGHZ |=> !mem_hiz_reg; endproperty
	a_hiz_off: assert property (p_hiz_off) else $error("hiz without code");
	property p_tdo_fall; !$stable(tdo_reg) |-> !tck; endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved, tck high");
	property p_oe_fall; !$stable(tdo_oe_reg) |-> !tck; endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("oe moved, tck high");
	property p_ir_rise; !$stable(ir_reg) |-> tck; endproperty
	a_ir_rise: assert property (p_ir_rise) else $error("ir moved, tck low");
	property p_bsr_sel;
		!$stable(bsr_upd_reg) |-> ir_reg == `JTBS_OP_HIGHZ || ir_reg == `JTBS_OP_SAMPLE;
	endproperty
	a_bsr_sel: assert property (p_bsr_sel) else $error("update without bsr");
	property p_unused; (bsr_upd_reg & ~USED_MASK) == '0; endproperty
	a_unused: assert property (p_unused) else $error("unused cell set");
	property p_rst_id; $rose(rst_n) |-> ir_reg == `JTBS_OP_IDCODE; endproperty
	a_rst_id: assert property (p_rst_id) else $error("no id after reset");
endmodule
bind jtbs_tap jtbs_tap_asserts #(.USED_MASK(USED_MASK)) chk (.core_clk(core_clk),
	.rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .ball_in(ball_in), .tdo_reg(tdo_reg),
	.tdo_oe_reg(tdo_oe_reg), .mem_hiz_reg(mem_hiz_reg), .bsr_upd_reg(bsr_upd_reg),
	.ir_reg(ir_reg));
`default_nettype wire

/* dv/jtbs_ctl_model.sv */
// behavioural boundary-scan controller on the test pins
// assumes a 40 ns core_clk; the test clock runs at 320 ns only in frames
`timescale 1ns/1ns
`default_nettype none
module jtbs_ctl_model (
	input  wire logic core_clk,
	input  wire logic tdo,
	input  wire logic tdo_oe,
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi
);
	// idle in test-logic-reset until the first step
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 320 ns test clock: four core cycles low with tms and tdi set up,
	// four high; tdo is taken just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		@(negedge core_clk);
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (4) @(negedge core_clk);
		// a released serial out has no pull, so it shows the inverse level
		q = tdo_oe ? tdo : ~tdo;
		tck = 1'b1;
		repeat (3) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

/* dv/tb_jtag_tap_id_bypass_chain.sv */
// self-checking bench for the test access port
// assumes the controller model and the checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"
module tb_jtag_tap_id_bypass_chain;
	localparam [3:0]   REV   = 4'ha;     // arbitrary value
	localparam [15:0]  DEV   = 16'h5c3e; // arbitrary value
	localparam [10:0]  VEN   = 11'h2a5;  // arbitrary value
	localparam [112:0] MASK  = {1'b0, {107{1'b1}}, 1'b0, {4{1'b1}}};
	localparam [112:0] BALLS = {1'b1, {56{2'b01}}};
	logic         core_clk = 1'b0;
	logic         rst_n    = 1'b0;
	logic [112:0] ball_in  = BALLS;
	logic         q;
	int           err_total = 0;
	int           checks_done = 0;
	wire logic         tck, tms, tdi, tdo, oe, hiz;
	wire logic [112:0] upd;
	wire logic [7:0]   ir;
	jtbs_tap #(.REVISION(REV), .DEVICE_ID(DEV), .VENDOR_ID(VEN), .USED_MASK(MASK)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.ball_in(ball_in), .tdo_reg(tdo), .tdo_oe_reg(oe), .mem_hiz_reg(hiz),
		.bsr_upd_reg(upd), .ir_reg(ir));
	jtbs_ctl_model ctl (.core_clk(core_clk), .tdo(tdo), .tdo_oe(oe), .tck(tck), .tms(tms),
		.tdi(tdi));
	always #20 core_clk = ~core_clk;
	task automatic cmp(input logic [112:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	// from idle: walk to shift-ir or shift-dr, shift n bits lsb first, update, idle
	task automatic scan(input logic ir_sel, input int n, input logic [112:0] din,
		output logic [112:0] dout);
		dout = '0;
		ctl.step(1'b1, 1'b0, q);
		if (ir_sel) ctl.step(1'b1, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			ctl.step(i == n - 1, din[i], q);
			dout[i] = q;
			cmp(oe, 1'b1, "oe during shift");
		end
		ctl.step(1'b1, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		repeat (2) @(negedge core_clk);
		cmp(oe, 1'b0, "oe after frame");
	endtask
	task automatic t_idcode;
		logic [112:0] o;
		cmp(ir, `JTBS_OP_IDCODE, "ir after reset");
		scan(1'b0, 32, '0, o);
		cmp(o[31:12], {REV, DEV}, "revision and device");
		cmp(o[11:1], VEN, "vendor");
		cmp(o[0], `JTBS_ID_PRESENT, "presence bit");
	endtask
	task automatic t_bypass;
		logic [112:0] o;
		scan(1'b1, 8, `JTBS_OP_BYPASS, o);
		cmp(o[7:0], `JTBS_IR_CAPTURE, "ir capture");
		cmp(ir, `JTBS_OP_BYPASS, "bypass code");
		scan(1'b0, 9, 113'h1b4, o);
		cmp(o[8:0], {8'hb4, 1'b0}, "bypass path");
		cmp(o[0], 1'b0, "bypass capture");
		cmp(hiz, 1'b0, "bypass floats outputs");
	endtask
	// sample then shift the whole chain, cell 1 first, loading the update latch
	task automatic t_sample;
		logic [112:0] o;
		scan(1'b1, 8, `JTBS_OP_SAMPLE, o);
		scan(1'b0, 113, ~BALLS, o);
		cmp(o, BALLS & MASK, "capture order");
		cmp(upd, ~BALLS & MASK, "update latch");
	endtask
	task automatic t_highz;
		logic [112:0] o;
		scan(1'b1, 8, `JTBS_OP_HIGHZ, o);
		cmp(hiz, 1'b1, "outputs not floated");
		scan(1'b0, 113, BALLS, o);
		cmp(o, BALLS & MASK, "bsr in highz");
	endtask
	// five ones on tms return to test-logic-reset without the reset pin
	task automatic t_tlr;
		repeat (5) ctl.step(1'b1, 1'b0, q);
		repeat (2) @(negedge core_clk);
		cmp(ir, `JTBS_OP_IDCODE, "ir after tlr");
		cmp(hiz, 1'b0, "hiz after tlr");
		ctl.step(1'b0, 1'b0, q);
	endtask
	task automatic close_out;
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence; inputs move on falling clock edges
	initial begin
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		ctl.step(1'b0, 1'b0, q);
		t_idcode();
		t_bypass();
		t_sample();
		t_highz();
		t_tlr();
		close_out();
	end
	// the run needs about 0.11 ms; give it ample margin
	initial begin
		#2000000;
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
